// ==== hdl/sqo_top.sv ====
// file: serial i/q output port with its two control words
// Notes on behaviour
// - word five sets length and bit order
// - address 110 selects the format word
// - update bit: addressed only, or all words
// - bit 35 sends q after i on i pin
// - six-bit slot number picks our time slot
// - bit 28 sets clock edge and idle level
// - bit 27: one-cycle active phase or half duty
// - bit 26: gated or continuous bit clock
// - bit clock pin three-state mode
// - strobe polarity and position
// - strobe pin three-state mode
// - i data inversion and three-state mode
// - q data inversion on the q pin only, and three-state mode
// - rate preload kept within 2 to 1701
`timescale 1ns/1ps
module sqo_top #(
    parameter int SAMP_W = 16
) (
    input wire logic clk_i,
    input wire logic arst_n_i,
    input wire logic ser_clk_i,
    input wire logic ser_en_i,
    input wire logic ser_data_i,
    input wire logic iq_valid_i,
    input wire logic [37:0] i_data_i,
    input wire logic [37:0] q_data_i,
    input wire logic [SAMP_W-1:0] samp_raw_i,
    output logic iq_ready_o,
    output logic [SAMP_W-1:0] samp_o,
    output sqo_pkg::sqo_pin_s pins_o
);
    // refuse a sample too narrow for the sign flip
    if (SAMP_W < 2) begin : g_bad_width
        $error("sample width too small");
    end

    typedef struct packed {
        sqo_pkg::sqo_state_e state;
        logic pend;
        logic rdy;
        logic [37:0] ish;
        logic [37:0] qsh;
        logic [12:0] rc;
        logic [6:0] bcnt;
        logic [5:0] scnt;
        logic wsel;
        logic tgl_d;
        sqo_pkg::sqo_cfg5_s s5;
        sqo_pkg::sqo_cfg6_s s6;
        sqo_pkg::sqo_cfg5_s c5;
        sqo_pkg::sqo_cfg6_s c6;
        sqo_pkg::sqo_pin_s pins;
        logic [SAMP_W-1:0] samp;
    } sqo_top_st_s;

    sqo_top_st_s s_r, s_nxt;
    logic [1:0] rst_sync_r;
    logic rst_n;
    logic [39:0] cmd_word;
    logic cmd_tgl;
    logic tgl_sync;
    logic new_cmd;
    logic tick;
    logic [12:0] pre;
    logic [5:0] nb;
    logic [6:0] slot_len;
    logic in_slot;
    logic ck_act;
    logic [2:0] cmd_addr;

    // output word length from its two-bit code
    function automatic logic [5:0] nbits_of(input logic [1:0] code);
        case (code)
            2'b00: nbits_of = 6'h10;
            2'b01: nbits_of = 6'h18;
            2'b10: nbits_of = 6'h20;
            default: nbits_of = 6'h26;
        endcase
    endfunction

    // pick bit k of a word, msb or lsb first, top nb bits used
    function automatic logic pick_bit(input logic [37:0] w, input logic [6:0] k,
                                      input logic [5:0] n, input logic msb);
        logic [6:0] idx;
        idx = msb ? (7'h25 - k) : (7'h26 - {1'b0, n} + k);
        pick_bit = w[idx[5:0]];
    endfunction

    // pin enable from a three-state code
    function automatic logic pin_oe(input logic [1:0] ts, input logic slot);
        pin_oe = ts[1] ? slot : ts[0];
    endfunction

    // reset release through two flops
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rst_sync_r <= 2'b00;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    sqo_cmd_rx u_cmd_rx (
        .ser_clk_i(ser_clk_i),
        .arst_n_i(arst_n_i),
        .ser_en_i(ser_en_i),
        .ser_data_i(ser_data_i),
        .word_o(cmd_word),
        .tgl_o(cmd_tgl)
    );

    sqo_sync #(.W(1)) u_tgl_sync (
        .clk_i(clk_i),
        .rst_n_i(rst_n),
        .d_i(cmd_tgl),
        .q_o(tgl_sync)
    );

    // derived timing terms
    always_comb begin
        pre = s_r.c6.preload;
        if (pre < sqo_pkg::PRELOAD_MIN) begin
            pre = sqo_pkg::PRELOAD_MIN;
        end else if (pre > sqo_pkg::PRELOAD_MAX) begin
            pre = sqo_pkg::PRELOAD_MAX;
        end
        tick = (s_r.rc == 13'h0000);
        nb = nbits_of(s_r.c5.nbits);
        slot_len = s_r.c6.iq_mux ? (7'({nb, 1'b0}) + 7'h01) : (7'(nb) + 7'h01);
        in_slot = (s_r.state == sqo_pkg::ST_LEAD) || (s_r.state == sqo_pkg::ST_SHIFT);
        ck_act = s_r.c6.ck_duty ? (s_r.rc > (pre >> 1)) : (s_r.rc == pre);
        new_cmd = (tgl_sync != s_r.tgl_d);
        cmd_addr = cmd_word[sqo_pkg::ADDR_HI:sqo_pkg::ADDR_LO];
    end

    // next state: commands, sample capture, slot sequencer, pins
    always_comb begin
        s_nxt = s_r;
        s_nxt.tgl_d = tgl_sync;
        s_nxt.rc = tick ? pre : (s_r.rc - 13'h0001);
        if (new_cmd) begin
            if (cmd_addr == sqo_pkg::ADDR_DEC_OUT) begin
                s_nxt.s5 = cmd_word;
            end
            if (cmd_addr == sqo_pkg::ADDR_IO_FMT) begin
                s_nxt.s6 = cmd_word;
            end
            if (cmd_word[sqo_pkg::UPD_POS]) begin
                s_nxt.c5 = (cmd_addr == sqo_pkg::ADDR_DEC_OUT) ? cmd_word : s_r.s5;
                s_nxt.c6 = (cmd_addr == sqo_pkg::ADDR_IO_FMT) ? cmd_word : s_r.s6;
            end else if (cmd_addr == sqo_pkg::ADDR_DEC_OUT) begin
                s_nxt.c5 = cmd_word;
            end else if (cmd_addr == sqo_pkg::ADDR_IO_FMT) begin
                s_nxt.c6 = cmd_word;
            end
        end
        if (iq_valid_i && !s_r.pend) begin
            s_nxt.ish = i_data_i;
            s_nxt.qsh = q_data_i;
            s_nxt.pend = 1'b1;
        end
        if (tick) begin
            unique case (s_r.state)
                sqo_pkg::ST_IDLE: begin
                    s_nxt.bcnt = '0;
                    s_nxt.scnt = '0;
                    if (s_r.pend) begin
                        s_nxt.state = (s_r.c6.slot == 6'h00) ? sqo_pkg::ST_LEAD
                                                              : sqo_pkg::ST_WAIT;
                    end
                end
                sqo_pkg::ST_WAIT: begin
                    s_nxt.bcnt = s_r.bcnt + 7'h01;
                    if (s_r.bcnt == slot_len - 7'h01) begin
                        s_nxt.bcnt = '0;
                        s_nxt.scnt = s_r.scnt + 6'h01;
                        if (s_r.scnt + 6'h01 == s_r.c6.slot) begin
                            s_nxt.state = sqo_pkg::ST_LEAD;
                        end
                    end
                end
                sqo_pkg::ST_LEAD: begin
                    s_nxt.state = sqo_pkg::ST_SHIFT;
                    s_nxt.bcnt = '0;
                    s_nxt.wsel = 1'b0;
                end
                sqo_pkg::ST_SHIFT: begin
                    s_nxt.bcnt = s_r.bcnt + 7'h01;
                    if (s_r.bcnt == 7'(nb) - 7'h01) begin
                        s_nxt.bcnt = '0;
                        if (s_r.c6.iq_mux && !s_r.wsel) begin
                            s_nxt.wsel = 1'b1;
                        end else begin
                            s_nxt.state = sqo_pkg::ST_IDLE;
                            s_nxt.pend = 1'b0;
                        end
                    end
                end
            endcase
        end
        s_nxt.rdy = ~s_nxt.pend;
        // bit clock: idle level is the inverse of the polarity bit
        s_nxt.pins.clk = ~s_r.c6.ck_pol ^
                         (ck_act & (s_r.c6.ck_cont | (s_r.state == sqo_pkg::ST_SHIFT)));
        s_nxt.pins.clk_oe = pin_oe(s_r.c6.ck_ts, in_slot);
        s_nxt.pins.stb = s_r.c6.sb_pol ^
                         (s_r.c6.sb_loc ? (s_r.state == sqo_pkg::ST_SHIFT)
                                        : (s_r.state == sqo_pkg::ST_LEAD));
        s_nxt.pins.stb_oe = pin_oe(s_r.c6.sb_ts, in_slot);
        s_nxt.pins.i = s_r.c6.i_inv ^ ((s_r.state == sqo_pkg::ST_SHIFT) &&
                       pick_bit(s_r.wsel ? s_r.qsh : s_r.ish, s_r.bcnt, nb, s_r.c5.msb_first));
        s_nxt.pins.i_oe = pin_oe(s_r.c6.i_ts, in_slot);
        s_nxt.pins.q = s_r.c6.q_inv ^ ((s_r.state == sqo_pkg::ST_SHIFT) &&
                       !s_r.c6.iq_mux && pick_bit(s_r.qsh, s_r.bcnt, nb, s_r.c5.msb_first));
        s_nxt.pins.q_oe = pin_oe(s_r.c6.q_ts, in_slot);
        // offset binary turns into twos complement by flipping the msb
        s_nxt.samp = samp_raw_i ^ {~s_r.c6.in_twos, {(SAMP_W-1){1'b0}}};
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
        if (!rst_n) begin
            s_r <= '0;
            s_r.c5 <= sqo_pkg::DEC_OUT_RST;
            s_r.c6 <= sqo_pkg::IO_FMT_RST;
            s_r.s5 <= sqo_pkg::DEC_OUT_RST;
            s_r.s6 <= sqo_pkg::IO_FMT_RST;
            s_r.rdy <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign iq_ready_o = s_r.rdy;
    assign samp_o = s_r.samp;
    assign pins_o = s_r.pins;

    // checks
    a_rate_range: assert property (@(posedge clk_i) disable iff (!rst_n)
        s_r.rc <= sqo_pkg::PRELOAD_MAX) else $error("rate counter above limit");
    a_fmt_word_load: assert property (@(posedge clk_i) disable iff (!rst_n)
        new_cmd && cmd_addr == sqo_pkg::ADDR_IO_FMT |=> s_r.c6 == $past(cmd_word))
        else $error("format word not loaded");
    a_update_only: assert property (@(posedge clk_i) disable iff (!rst_n)
        new_cmd && !cmd_word[sqo_pkg::UPD_POS] && cmd_addr == sqo_pkg::ADDR_IO_FMT
        |=> $stable(s_r.c5)) else $error("other word changed");
    a_clk_idle_gated: assert property (@(posedge clk_i) disable iff (!rst_n)
        s_r.state == sqo_pkg::ST_IDLE && !s_r.c6.ck_cont && $stable(s_r.c6)
        |=> s_r.pins.clk == !$past(s_r.c6.ck_pol)) else $error("gated clock toggled");
    a_slot_oe_off: assert property (@(posedge clk_i) disable iff (!rst_n)
        s_r.c6.i_ts[1] && s_r.state == sqo_pkg::ST_WAIT && $stable(s_r.c6)
        |=> !s_r.pins.i_oe) else $error("i pin driven outside slot");
    a_clk_ts_off: assert property (@(posedge clk_i) disable iff (!rst_n)
        s_r.c6.ck_ts == 2'b00 && $stable(s_r.c6) |=> !s_r.pins.clk_oe)
        else $error("bit clock driven in three-state");
    a_mux_q_quiet: assert property (@(posedge clk_i) disable iff (!rst_n)
        s_r.c6.iq_mux && $stable(s_r.c6) |=> s_r.pins.q == $past(s_r.c6.q_inv))
        else $error("q pin active in mux mode");
    a_stb_lead: assert property (@(posedge clk_i) disable iff (!rst_n)
        s_r.state == sqo_pkg::ST_LEAD && !s_r.c6.sb_loc && $stable(s_r.c6)
        |=> s_r.pins.stb == !$past(s_r.c6.sb_pol)) else $error("strobe missing before word");
    a_ready_drop: assert property (@(posedge clk_i) disable iff (!rst_n)
        iq_valid_i && iq_ready_o |=> !iq_ready_o ##1 !iq_ready_o)
        else $error("ready not dropped on capture");
    a_dec_word_load: assert property (@(posedge clk_i) disable iff (!rst_n)
        new_cmd && cmd_addr == sqo_pkg::ADDR_DEC_OUT |=> s_r.c5 == $past(cmd_word))
        else $error("output word not loaded");
    a_stb_ts_off: assert property (@(posedge clk_i) disable iff (!rst_n)
        s_r.c6.sb_ts == 2'b00 |=> !s_r.pins.stb_oe) else $error("strobe pin driven");
    a_q_ts_off: assert property (@(posedge clk_i) disable iff (!rst_n)
        s_r.c6.q_ts == 2'b00 |=> !s_r.pins.q_oe) else $error("q pin driven");
    a_i_oe_on: assert property (@(posedge clk_i) disable iff (!rst_n)
        s_r.c6.i_ts == 2'b01 |=> s_r.pins.i_oe) else $error("i pin not driven");
    a_stb_word: assert property (@(posedge clk_i) disable iff (!rst_n)
        s_r.state == sqo_pkg::ST_SHIFT && s_r.c6.sb_loc
        |=> s_r.pins.stb == !$past(s_r.c6.sb_pol)) else $error("strobe missing in word");
    a_wait_clk_idle: assert property (@(posedge clk_i) disable iff (!rst_n)
        s_r.state == sqo_pkg::ST_WAIT && !s_r.c6.ck_cont
        |=> s_r.pins.clk == !$past(s_r.c6.ck_pol)) else $error("clock toggled before slot");
    a_lead_i_quiet: assert property (@(posedge clk_i) disable iff (!rst_n)
        s_r.state == sqo_pkg::ST_LEAD
        |=> s_r.pins.i == $past(s_r.c6.i_inv)) else $error("i data before word");
    a_rate_reload: assert property (@(posedge clk_i) disable iff (!rst_n)
        tick |=> s_r.rc >= sqo_pkg::PRELOAD_MIN) else $error("rate preload below limit");
    a_clk_oe_on: assert property (@(posedge clk_i) disable iff (!rst_n)
        s_r.c6.ck_ts == 2'b01 |=> s_r.pins.clk_oe) else $error("bit clock not driven");
    a_clk_oe_slot: assert property (@(posedge clk_i) disable iff (!rst_n)
        s_r.c6.ck_ts[1] && in_slot |=> s_r.pins.clk_oe) else $error("bit clock off in slot");
    a_idle_q_quiet: assert property (@(posedge clk_i) disable iff (!rst_n)
        s_r.state == sqo_pkg::ST_IDLE && !s_r.c6.iq_mux
        |=> s_r.pins.q == $past(s_r.c6.q_inv)) else $error("q data outside word");

    // covers of the main scenarios
    c_msb_long: cover property (@(posedge clk_i) disable iff (!rst_n)
        s_r.c5.msb_first && s_r.c5.nbits == 2'b11 && s_r.state == sqo_pkg::ST_SHIFT);
    c_upd_all: cover property (@(posedge clk_i) disable iff (!rst_n)
        new_cmd && cmd_word[sqo_pkg::UPD_POS]);
    c_mux_word: cover property (@(posedge clk_i) disable iff (!rst_n)
        s_r.c6.iq_mux && s_r.wsel && s_r.state == sqo_pkg::ST_SHIFT);
    c_late_slot: cover property (@(posedge clk_i) disable iff (!rst_n)
        s_r.state == sqo_pkg::ST_WAIT ##[1:1000] s_r.state == sqo_pkg::ST_LEAD);
    c_cont_clk: cover property (@(posedge clk_i) disable iff (!rst_n)
        s_r.c6.ck_cont && s_r.state == sqo_pkg::ST_IDLE && s_r.pins.clk == s_r.c6.ck_pol);
endmodule

// ==== hdl/sqo_pkg.sv ====
// package: constants, field layouts and types of the serial i/q output block
package sqo_pkg;
    // command word destinations (bits 39-37)
    localparam logic [2:0] ADDR_DEC_OUT = 3'h5;
    localparam logic [2:0] ADDR_IO_FMT = 3'h6;
    localparam int CMD_W = 40;
    localparam int CMD_LAST = 39;
    localparam int ADDR_HI = 39;
    localparam int ADDR_LO = 37;
    localparam int UPD_POS = 36;
    // sample word as handed over by the filter chain
    localparam int IQ_W = 38;
    // bit clock rate counter preload limits
    localparam logic [12:0] PRELOAD_MIN = 13'h0002;
    localparam logic [12:0] PRELOAD_MAX = 13'h06A5;
    // reset values of both control words
    localparam logic [39:0] DEC_OUT_RST = 40'h00_0000_0000;
    localparam logic [39:0] IO_FMT_RST = 40'h00_0000_0000;

    // decimation/output word; only the low three bits matter here
    typedef struct packed {
        logic [2:0] addr;
        logic upd;
        logic [32:0] other;
        logic [1:0] nbits;
        logic msb_first;
    } sqo_cfg5_s;

    // input and output format word, bit 39 down to bit 0
    typedef struct packed {
        logic [2:0] addr;
        logic upd;
        logic iq_mux;
        logic [5:0] slot;
        logic ck_pol;
        logic ck_duty;
        logic ck_cont;
        logic [1:0] ck_ts;
        logic sb_pol;
        logic sb_loc;
        logic [1:0] sb_ts;
        logic i_inv;
        logic [1:0] i_ts;
        logic q_inv;
        logic [1:0] q_ts;
        logic in_twos;
        logic [12:0] preload;
    } sqo_cfg6_s;

    // output pins with their enables
    typedef struct packed {
        logic clk;
        logic clk_oe;
        logic stb;
        logic stb_oe;
        logic i;
        logic i_oe;
        logic q;
        logic q_oe;
    } sqo_pin_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_WAIT = 2'b01,
        ST_LEAD = 2'b10,
        ST_SHIFT = 2'b11
    } sqo_state_e;
endpackage

// ==== hdl/sqo_sync.sv ====
// file: two flip-flop level synchroniser
`timescale 1ns/1ps
module sqo_sync #(
    parameter int W = 1
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] sync;
    } sqo_sync_st_s;

    sqo_sync_st_s s_r, s_nxt;

    // first stage feeds only the second
    always_comb begin
        s_nxt.meta = d_i;
        s_nxt.sync = s_r.meta;
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign q_o = s_r.sync;
endmodule

// ==== hdl/sqo_cmd_rx.sv ====
// file: 40-bit serial command shifter on the command port clock
`timescale 1ns/1ps
module sqo_cmd_rx (
    input wire logic ser_clk_i,
    input wire logic arst_n_i,
    input wire logic ser_en_i,
    input wire logic ser_data_i,
    output logic [39:0] word_o,
    output logic tgl_o
);
    typedef struct packed {
        logic [38:0] sh;
        logic [5:0] cnt;
        logic [39:0] word;
        logic tgl;
    } sqo_rx_st_s;

    sqo_rx_st_s s_r, s_nxt;

    // msb first; word held stable until the next one completes
    always_comb begin
        s_nxt = s_r;
        if (ser_en_i) begin
            if (s_r.cnt == 6'(sqo_pkg::CMD_LAST)) begin
                s_nxt.word = {s_r.sh, ser_data_i};
                s_nxt.tgl = ~s_r.tgl;
                s_nxt.cnt = '0;
            end else begin
                s_nxt.sh = {s_r.sh[37:0], ser_data_i};
                s_nxt.cnt = s_r.cnt + 6'h01;
            end
        end
    end

    always_ff @(posedge ser_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign word_o = s_r.word;
    assign tgl_o = s_r.tgl;
endmodule

// ==== verif/sqo_rx_model.sv ====
// far-side receiver model: samples serial i/q pins at the stable bit clock edge
`timescale 1ns/1ps
module sqo_rx_model (
    input wire logic clk_i,
    input wire logic clr_i,
    input wire logic pol_i,
    input wire logic sb_pol_i,
    input wire sqo_pkg::sqo_pin_s pins_i,
    output logic [75:0] cap_o,
    output logic [37:0] qcap_o,
    output logic [7:0] nbit_o,
    output logic [15:0] per_o,
    output logic [15:0] stb_n_o,
    output logic [15:0] ioe_n_o
);
    logic ck_q = 1'b0;
    logic [15:0] gap = '0;
    logic iv;
    logic qv;
    // an undriven pin shows the opposite level, never a lucky match
    assign iv = pins_i.i_oe ? pins_i.i : !pins_i.i;
    assign qv = pins_i.q_oe ? pins_i.q : !pins_i.q;
    // capture bits, bit period and strobe/enable widths
    always @(posedge clk_i) begin
        ck_q <= pins_i.clk;
        if (clr_i) begin
            cap_o <= '0;
            qcap_o <= '0;
            nbit_o <= '0;
            per_o <= '0;
            stb_n_o <= '0;
            ioe_n_o <= '0;
            gap <= '0;
        end else begin
            gap <= gap + 16'h0001;
            if (pins_i.stb_oe && pins_i.stb != sb_pol_i) stb_n_o <= stb_n_o + 16'h0001;
            if (pins_i.i_oe) ioe_n_o <= ioe_n_o + 16'h0001;
            // rising edge for polarity 0, falling edge for 1
            if (pins_i.clk_oe && pins_i.clk != ck_q && pins_i.clk == !pol_i) begin
                cap_o <= {cap_o[74:0], iv};
                qcap_o <= {qcap_o[36:0], qv};
                nbit_o <= nbit_o + 8'h01;
                per_o <= gap + 16'h0001;
                gap <= '0;
            end
        end
    end
endmodule

// ==== verif/sqo_tb.sv ====
// testbench: random output frames through the serial i/q port
`timescale 1ns/1ps
module serial_iq_output_format_control_tb_top;
    logic clk_i = 1'b0;
    logic arst_n_i = 1'b0;
    logic ser_clk_i = 1'b0;
    logic ser_en_i = 1'b0;
    logic ser_data_i = 1'b0;
    logic iq_valid_i = 1'b0;
    logic [37:0] i_data_i = '0;
    logic [37:0] q_data_i = '0;
    logic [15:0] samp_raw_i = '0;
    logic iq_ready_o;
    logic [15:0] samp_o;
    sqo_pkg::sqo_pin_s pins_o;
    logic clr = 1'b1;
    logic [75:0] cap;
    logic [37:0] qcap;
    logic [7:0] nbit;
    logic [15:0] per, stb_n, ioe_n;
    sqo_pkg::sqo_cfg5_s c5;
    sqo_pkg::sqo_cfg6_s c6;
    logic [63:0] r64;
    logic [31:0] seed = 32'h01439E4A;
    int errors = 0;
    int n_compared = 0;
    int p;

    sqo_top #(.SAMP_W(16)) DUT (.clk_i(clk_i), .arst_n_i(arst_n_i), .ser_clk_i(ser_clk_i),
        .ser_en_i(ser_en_i), .ser_data_i(ser_data_i), .iq_valid_i(iq_valid_i),
        .i_data_i(i_data_i), .q_data_i(q_data_i), .samp_raw_i(samp_raw_i),
        .iq_ready_o(iq_ready_o), .samp_o(samp_o), .pins_o(pins_o));
    sqo_rx_model rx (.clk_i(clk_i), .clr_i(clr), .pol_i(c6.ck_pol), .sb_pol_i(c6.sb_pol),
        .pins_i(pins_o), .cap_o(cap), .qcap_o(qcap), .nbit_o(nbit), .per_o(per),
        .stb_n_o(stb_n), .ioe_n_o(ioe_n));

    // system clock
    initial begin
        forever #5 clk_i = ~clk_i;
    end

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // word bits in wire order, first bit highest
    function automatic logic [37:0] wseq(logic [37:0] w, int n, logic msb, logic inv);
        logic [37:0] r;
        r = '0;
        for (int k = 0; k < n; k++) r[n-1-k] = w[msb ? 37-k : 38-n+k] ^ inv;
        return r;
    endfunction

    task automatic check(logic [75:0] seen, logic [75:0] exp, string what);
        n_compared++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    // link clock runs only within a command frame
    task automatic send_cmd(logic [39:0] w);
        ser_en_i = 1'b1;
        for (int k = 39; k >= 0; k--) begin
            ser_data_i = w[k];
            #3 ser_clk_i = 1'b1;
            #3 ser_clk_i = 1'b0;
        end
        ser_en_i = 1'b0;
        repeat (6) @(posedge clk_i);
    endtask

    task automatic close_out();
        $display("compared %0d, errors %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // one i/q pair through the port, then compare what the receiver saw
    task automatic frame();
        int n;
        int w;
        int t;
        logic [75:0] ex;
        n = (c5.nbits == 2'h3) ? 38 : 16 + 8 * c5.nbits;
        p = (c6.preload < 2) ? 2 : c6.preload;
        send_cmd(c5);
        send_cmd(c6);
        #1 clr = 1'b0;
        r64 = {rnd(), rnd()};
        i_data_i = r64[37:0];
        samp_raw_i = r64[53:38];
        r64 = {rnd(), rnd()};
        q_data_i = r64[37:0];
        iq_valid_i = 1'b1;
        @(posedge clk_i);
        #1 iq_valid_i = 1'b0;
        ex = c6.in_twos ? samp_raw_i : {~samp_raw_i[15], samp_raw_i[14:0]};
        check(samp_o, ex, "sample format");
        check(iq_ready_o, 1'b0, "ready after take");
        t = (c6.slot * (n * (c6.iq_mux + 1) + 1) + n * (c6.iq_mux + 1) + 1) * (p + 1);
        for (w = 0; w < 5000 && iq_ready_o !== 1'b1; w++) begin
            @(posedge clk_i);
            #1;
        end
        check(w >= t + 1 && w <= t + p + 1, 1'b1, "slot timing");
        repeat (4) @(posedge clk_i);
        #1;
        check(iq_ready_o, 1'b1, "ready after frame");
        if (c6.i_ts != 2'h1) check(ioe_n, c6.i_ts[1] ? (n * (c6.iq_mux + 1) + 1) * (p + 1) : 0,
            "i enable width");
        if (c6.i_ts != 2'h0) begin
            ex = wseq(i_data_i, n, c5.msb_first, c6.i_inv);
            if (c6.iq_mux) ex = (ex << n) | wseq(q_data_i, n, c5.msb_first, c6.q_inv);
            check(cap, ex, "i pin bits");
            check(nbit, n * (c6.iq_mux + 1), "bit count");
            check(per, p + 1, "bit period");
        end
        if (!c6.iq_mux) check(qcap, wseq(q_data_i, n, c5.msb_first, c6.q_inv), "q pin");
        check(stb_n, (c6.sb_loc ? n : 1) * (p + 1), "strobe width");
        check(pins_o.clk, !c6.ck_pol, "clock idle level");
        @(posedge clk_i);
        #1 clr = 1'b1;
    endtask

    initial begin
        c6 = '0;
        repeat (2) @(posedge clk_i);
        #1;
        check({pins_o, iq_ready_o, samp_o}, {8'h00, 1'b1, 16'h0000}, "reset outputs");
        arst_n_i = 1'b1;
        repeat (5) @(posedge clk_i);
        for (int it = 0; it < 12; it++) begin
            r64 = {rnd(), rnd()};
            c5 = '0;
            c5.addr = sqo_pkg::ADDR_DEC_OUT;
            c5.nbits = r64[61:60];
            c5.msb_first = r64[62];
            c6 = r64[39:0];
            c6.addr = sqo_pkg::ADDR_IO_FMT;
            c6.upd = r64[52];
            c6.slot = {4'h0, r64[41:40]};
            c6.ck_cont = 1'b0;
            c6.sb_ts = {r64[48], 1'b1};
            c6.q_ts = {r64[49], 1'b1};
            if (c6.ck_ts == 2'h0) c6.ck_ts = 2'h2;
            if (c6.iq_mux) c6.q_inv = c6.i_inv;
            if (c6.iq_mux) c6.sb_loc = 1'b0;
            // preload from a decimation factor and slot length of 40
            c6.preload = (it == 0) ? 13'h0000 : 13'((30 + r64[47:42] % 41) * 4 / 40 - 1);
            if (it[0]) send_cmd({3'h7, 1'b0, r64[63:28]});
            frame();
        end
        // continuous clock keeps toggling with no frame
        c6.ck_cont = 1'b1;
        c6.ck_ts = 2'h1;
        send_cmd(c6);
        #1 clr = 1'b0;
        repeat (40) @(posedge clk_i);
        #1;
        check(nbit != 8'h00, 1'b1, "continuous clock");
        check(per, p + 1, "continuous period");
        c6.ck_ts = 2'h0;
        c6.sb_ts = 2'h0;
        send_cmd(c6);
        #1;
        check({pins_o.clk_oe, pins_o.stb_oe}, 2'h0, "three-state pins");
        close_out();
    end

    // watchdog against a hung handshake
    initial begin
        #600000;
        errors++;
        close_out();
    end
endmodule
